// [nco_accumulator.sv]
`timescale 1ns/1ps
module nco_accumulator (
  input wire logic clock,
  input wire logic rst,
  nco_if.acc ncoPort
);

  logic [tuner_pkg::PHASE_W-1:0] phase_reg;
  logic carry_reg;
  logic [tuner_pkg::PHASE_W-1:0] feedback;
  logic [tuner_pkg::PHASE_W:0] sum;

  // With load low the feedback is zeroed, so the phase sits at the
  // frequency word instead of advancing.
  always_comb begin
    feedback = ncoPort.load ? phase_reg : '0;
    sum = {1'b0, feedback} + {1'b0, ncoPort.freq};
  end

  always_ff @(posedge clock) begin
    if (rst || ncoPort.clear) begin
      phase_reg <= '0;
      carry_reg <= 1'b0;
    end else begin
      phase_reg <= sum[tuner_pkg::PHASE_W-1:0];
      carry_reg <= sum[tuner_pkg::PHASE_W];
    end
  end

  assign ncoPort.phase = phase_reg;
  assign ncoPort.carry = carry_reg;

endmodule

// [nco_if.sv]
`timescale 1ns/1ps
interface nco_if;
  logic [tuner_pkg::PHASE_W-1:0] freq;
  logic load;
  logic clear;
  logic [tuner_pkg::PHASE_W-1:0] phase;
  logic carry;
  modport ctrl(output freq, output load, output clear,
    input phase, input carry);
  modport acc(input freq, input load, input clear,
    output phase, output carry);
endinterface

// [output_forcer.sv]
`timescale 1ns/1ps
module output_forcer (
  input wire logic clock,
  input wire logic rst,
  input wire logic testMode,
  input wire logic [31:0] forceWord,
  input wire logic [tuner_pkg::SPH_W-1:0] samplePhaseIn,
  input wire logic sampleStrobeIn,
  input wire logic levelCompareIn,
  input wire logic [tuner_pkg::IQ_W-1:0] inphaseIn,
  input wire logic dataReadyIn,
  input wire logic terminalIn,
  input wire logic [tuner_pkg::IQ_W-1:0] quadratureIn,
  output logic [tuner_pkg::SPH_W-1:0] samplePhaseOut,
  output logic sampleStrobeOut,
  output logic levelCompareOut,
  output logic [tuner_pkg::IQ_W-1:0] inphaseOut,
  output logic dataReadyOut,
  output logic terminalOut,
  output logic [tuner_pkg::IQ_W-1:0] quadratureOut
);

  always_ff @(posedge clock) begin
    if (rst) begin
      samplePhaseOut <= '0;
      sampleStrobeOut <= 1'b0;
      levelCompareOut <= 1'b0;
      inphaseOut <= '0;
      dataReadyOut <= 1'b0;
      terminalOut <= 1'b0;
      quadratureOut <= '0;
    end else if (testMode) begin // RL13
      samplePhaseOut <= forceWord[tuner_pkg::TST_SPH_LO +: // RL8
        tuner_pkg::SPH_W];
      sampleStrobeOut <= forceWord[tuner_pkg::TST_STROBE]; // RL9
      levelCompareOut <= forceWord[tuner_pkg::TST_LEVEL]; // RL9
      inphaseOut <= forceWord[tuner_pkg::TST_I_LO +: tuner_pkg::IQ_W]; // RL10
      dataReadyOut <= forceWord[tuner_pkg::TST_READY]; // RL11
      terminalOut <= forceWord[tuner_pkg::TST_TERMINAL]; // RL11
      // RL12 RL15
      quadratureOut <= forceWord[tuner_pkg::TST_Q_LO +: tuner_pkg::IQ_W];
    end else begin
      samplePhaseOut <= samplePhaseIn;
      sampleStrobeOut <= sampleStrobeIn;
      levelCompareOut <= levelCompareIn;
      inphaseOut <= inphaseIn;
      dataReadyOut <= dataReadyIn;
      terminalOut <= terminalIn;
      quadratureOut <= quadratureIn;
    end
  end

endmodule

// [test_tuner_control.sv]
`timescale 1ns/1ps
module test_tuner_control;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wrStrobe, rdStrobe;
  logic [2:0] busAddr;
  logic [7:0] controlBusIn, controlBusOut;
  logic controlBusOeN;
  logic [31:0] carrierFreq = 32'h0100_0000;
  logic [31:0] resampFreq = 32'h0800_0000;
  logic [9:0] inphaseIn = 10'h2a5;
  logic [9:0] quadratureIn = 10'h15a;
  logic dataReadyIn = 1'b1;
  logic levelCompareIn = 1'b1;
  logic [7:0] agcAccumIn = 8'h00;
  logic [4:0] samplePhaseOut;
  logic sampleStrobeOut, outputDataReady, levelCompareOut;
  logic [9:0] inphaseOut, quadratureOut;
  logic carrierTerminalPhaseOut, clearAccumulators;
  logic [7:0] carrierPhaseOut;
  int mismatches = 0;
  int nCompared = 0;
  logic [31:0] a, b, w;
  logic [7:0] rd;

  always #5 clock = ~clock;

  tuner_control u_dut (.clock(clock), .rst(rst), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .busAddr(busAddr), .controlBusIn(controlBusIn),
    .controlBusOut(controlBusOut), .controlBusOeN(controlBusOeN),
    .carrierFreq(carrierFreq), .resampFreq(resampFreq),
    .inphaseIn(inphaseIn), .quadratureIn(quadratureIn),
    .dataReadyIn(dataReadyIn), .levelCompareIn(levelCompareIn),
    .agcAccumIn(agcAccumIn), .samplePhaseOut(samplePhaseOut),
    .sampleStrobeOut(sampleStrobeOut), .outputDataReady(outputDataReady),
    .levelCompareOut(levelCompareOut), .inphaseOut(inphaseOut),
    .quadratureOut(quadratureOut),
    .carrierTerminalPhaseOut(carrierTerminalPhaseOut),
    .carrierPhaseOut(carrierPhaseOut),
    .clearAccumulators(clearAccumulators));

  tuner_host u_host (.clock(clock), .controlBusOut(controlBusOut),
    .controlBusOeN(controlBusOeN), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .busAddr(busAddr), .controlBusIn(controlBusIn));

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Two samples one clock apart, to measure a per-cycle step.
  task automatic step(input int n, ref logic [31:0] x, ref logic [31:0] y,
                      input logic sel);
    settle(n);
    x = sel ? 32'(samplePhaseOut) : 32'(carrierPhaseOut);
    settle(1);
    y = sel ? 32'(samplePhaseOut) : 32'(carrierPhaseOut);
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // -------------------------------------------------------------------
  // Tests
  // -------------------------------------------------------------------
  initial begin
    settle(6);
    rst = 1'b0;
    settle(1);
    check("oe_clear", 32'h2, {controlBusOeN, clearAccumulators});
    $display("test reset done");

    // The first forcing pattern sets reserved bits 31:29, which must vanish.
    u_host.write_word(4'h8, 32'hfaaa_aaaa);
    settle(2);
    check("passthrough", {quadratureIn, dataReadyIn, inphaseIn,
      levelCompareIn}, {quadratureOut, outputDataReady, inphaseOut,
      levelCompareOut});
    u_host.write_word(4'h4, 32'h0000_0008);
    for (int p = 0; p < 2; p++) begin
      w = p ? 32'h1555_5555 : 32'hfaaa_aaaa;
      if (p) u_host.write_word(4'h8, w);
      settle(2);
      check("forced", w & 32'h1fff_ffff, {quadratureOut,
        carrierTerminalPhaseOut, outputDataReady, inphaseOut,
        levelCompareOut, sampleStrobeOut, samplePhaseOut});
    end
    u_host.write_word(4'h4, 32'h0000_0000);
    u_host.write_word(4'hf, 32'h0000_0008);
    settle(2);
    check("unforced", {quadratureIn, inphaseIn}, {quadratureOut,
      inphaseOut});
    $display("test forcing done");

    u_host.write_word(4'h6, 32'h0000_4600);
    settle(3);
    check("clear_level", 32'h1, clearAccumulators);
    check("held_phase", 32'h0, carrierPhaseOut);
    settle(4);
    check("held_carry", 32'h0, {carrierPhaseOut,
      carrierTerminalPhaseOut});
    u_host.write_word(4'h7, 32'hffff_ff80);
    settle(2);
    check("offset_min", 32'h80, carrierPhaseOut);
    u_host.write_word(4'h7, 32'h0000_007f);
    settle(2);
    check("offset_max", 32'h7f, carrierPhaseOut);
    u_host.write_word(4'h7, 32'h0000_0000);
    $display("test clear and offset done");

    u_host.write_word(4'h6, 32'h0000_0600);
    step(3, a, b, 1'b0);
    check("clear_off", 32'h0, clearAccumulators);
    check("carrier_step", 32'h1, (b - a) & 32'hff);
    u_host.write_word(4'h6, 32'h0000_0400);
    step(3, a, b, 1'b0);
    check("carrier_gated", a, b);
    check("carrier_held", 32'h1, b);
    $display("test carrier done");

    // Step of 8 at bit 24 shows up as 8 >> sel in the selected field.
    for (int s = 0; s < 4; s++) begin
      u_host.write_word(4'h6, 32'h0000_2600 | (32'(s) << 11));
      step(3, a, b, 1'b1);
      check("sph_step", 32'h8 >> s, (b - a) & 32'h1f);
    end
    dataReadyIn = 1'b0;
    u_host.write_word(4'h6, 32'h0000_0600);
    step(3, a, b, 1'b1);
    check("sph_wait", a, b);
    dataReadyIn = 1'b1;
    step(3, a, b, 1'b1);
    check("sph_ready", 32'h8, (b - a) & 32'h1f);
    u_host.write_word(4'h6, 32'h0000_2200);
    step(3, a, b, 1'b1);
    check("resamp_gated", a, b);
    check("resamp_held", 32'h8, b);
    $display("test sample phase done");

    agcAccumIn = 8'h5a;
    u_host.write_word(4'h9, 32'h0000_0000);
    agcAccumIn = 8'hc3;
    u_host.read_byte(rd);
    check("agc_read", 32'h5a, rd);
    settle(2);
    check("bus_released", 32'h1, controlBusOeN);
    $display("test agc done");
    print_verdict();
  end

  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    print_verdict();
  end
endmodule

// [tuner_control.sv]
// What this block does
// [RL1] Config bit 9 gates carrier NCO feedback
// [RL2] Config bit 10 gates resampler NCO feedback
// [RL3] Select field picks five resampler phase bits
// [RL4] Bit 13: continuous or data-ready phase update
// [RL5] Bit 14 holds accumulators at zero
// [RL6] Clear reaches carrier, resampler, external accumulators
// [RL7] Signed offset byte adds pi*n/128 phase
// [RL8] Test mode forces sample phase pins
// [RL9] Test mode forces strobe and level outputs
// [RL10] Test mode forces in-phase outputs
// [RL11] Test mode forces ready and terminal outputs
// [RL12] Test mode forces quadrature outputs
// [RL13] Forcing only while test enable bit set
// [RL14] Destination 9 write captures AGC accumulator
// [RL15] Bit 28 drives quadrature MSB
// [RL16] Reserved bits ignored on write
`timescale 1ns/1ps
module tuner_control (
  input wire logic clock,
  input wire logic rst,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [2:0] busAddr,
  input wire logic [7:0] controlBusIn,
  output logic [7:0] controlBusOut,
  output logic controlBusOeN,
  input wire logic [31:0] carrierFreq,
  input wire logic [31:0] resampFreq,
  input wire logic [9:0] inphaseIn,
  input wire logic [9:0] quadratureIn,
  input wire logic dataReadyIn,
  input wire logic levelCompareIn,
  input wire logic [7:0] agcAccumIn,
  output logic [4:0] samplePhaseOut,
  output logic sampleStrobeOut,
  output logic outputDataReady,
  output logic levelCompareOut,
  output logic [9:0] inphaseOut,
  output logic [9:0] quadratureOut,
  output logic carrierTerminalPhaseOut,
  output logic [7:0] carrierPhaseOut,
  output logic clearAccumulators
);

  // ---------------------------------------------------------------------
  // Control words
  // ---------------------------------------------------------------------
  logic [31:0] hold_reg;
  logic [31:0] chipConfig_reg;
  logic [7:0] phaseOffset_reg;
  logic [31:0] outputForce_reg;
  logic testMode_reg;
  logic [7:0] agcSample_reg;
  logic [7:0] busOut_reg;
  logic busOeN_reg;
  logic [4:0] samplePhase_reg;
  logic sampleStrobe_reg;
  logic [7:0] carrierPhase_reg;
  logic clear_reg;
  logic transfer;
  logic [3:0] dest;
  logic [31:0] chipConfig_next;
  logic phaseUpdate;

  assign transfer = wrStrobe && (busAddr == tuner_pkg::ADDR_TRANSFER);
  assign dest = controlBusIn[tuner_pkg::DEST_W-1:0];

  // Words are assembled a byte at a time and only take effect when the
  // transfer names a destination, so a half-written word never steers
  // the datapath.
  always_ff @(posedge clock) begin
    if (rst) begin
      hold_reg <= tuner_pkg::WORD_RESET;
    end else if (wrStrobe) begin
      unique case (busAddr)
        tuner_pkg::ADDR_HOLD0: hold_reg[7:0] <= controlBusIn;
        tuner_pkg::ADDR_HOLD1: hold_reg[15:8] <= controlBusIn;
        tuner_pkg::ADDR_HOLD2: hold_reg[23:16] <= controlBusIn;
        tuner_pkg::ADDR_HOLD3: hold_reg[31:24] <= controlBusIn;
        default: hold_reg <= hold_reg;
      endcase
    end
  end

  // Only bits 14 to 9 steer this block; the rest are stored as
  // zero and the reserved field is never kept.
  always_comb begin
    chipConfig_next = '0;
    chipConfig_next[tuner_pkg::CFG_CLEAR:tuner_pkg::CFG_CARRIER_LOAD] =
      hold_reg[tuner_pkg::CFG_CLEAR:tuner_pkg::CFG_CARRIER_LOAD]; // RL16
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      chipConfig_reg <= tuner_pkg::CHIP_CONFIG_RESET;
    end else if (transfer && dest == tuner_pkg::DEST_CHIP_CONFIG) begin
      chipConfig_reg <= chipConfig_next;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      phaseOffset_reg <= tuner_pkg::BYTE_RESET;
    end else if (transfer && dest == tuner_pkg::DEST_PHASE_OFFSET) begin
      phaseOffset_reg <= hold_reg[tuner_pkg::OFFSET_W-1:0]; // RL16
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      outputForce_reg <= tuner_pkg::WORD_RESET;
    end else if (transfer && dest == tuner_pkg::DEST_OUTPUT_FORCE) begin
      outputForce_reg <= {3'h0, hold_reg[28:0]}; // RL16
    end
  end

  // Of the decimation control word only the test enable lives here.
  always_ff @(posedge clock) begin
    if (rst) begin
      testMode_reg <= 1'b0;
    end else if (transfer && dest == tuner_pkg::DEST_DECIM_CTRL) begin
      testMode_reg <= hold_reg[tuner_pkg::DECIM_TEST_EN]; // RL13
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      agcSample_reg <= tuner_pkg::BYTE_RESET;
    end else if (transfer && dest == tuner_pkg::DEST_AGC_SAMPLE) begin
      agcSample_reg <= agcAccumIn; // RL14
    end
  end

  // ---------------------------------------------------------------------
  // Read back
  // ---------------------------------------------------------------------
  // The bus drives only while a read is held; the captured AGC byte is
  // the only readable value so the host cannot see a moving accumulator.
  always_ff @(posedge clock) begin
    if (rst) begin
      busOut_reg <= tuner_pkg::BYTE_RESET;
      busOeN_reg <= 1'b1;
    end else begin
      busOut_reg <= rdStrobe ? agcSample_reg : tuner_pkg::BYTE_RESET; // RL14
      busOeN_reg <= !rdStrobe;
    end
  end

  // ---------------------------------------------------------------------
  // Oscillators
  // ---------------------------------------------------------------------
  nco_if carrierIf();
  nco_if resampIf();

  assign carrierIf.freq = carrierFreq;
  assign carrierIf.load = chipConfig_reg[tuner_pkg::CFG_CARRIER_LOAD]; // RL1
  assign carrierIf.clear = chipConfig_reg[tuner_pkg::CFG_CLEAR]; // RL5
  assign resampIf.freq = resampFreq;
  assign resampIf.load = chipConfig_reg[tuner_pkg::CFG_RESAMP_LOAD]; // RL2
  assign resampIf.clear = chipConfig_reg[tuner_pkg::CFG_CLEAR]; // RL6

  nco_accumulator carrierNco (
    .clock(clock),
    .rst(rst),
    .ncoPort(carrierIf.acc)
  );

  nco_accumulator resampNco (
    .clock(clock),
    .rst(rst),
    .ncoPort(resampIf.acc)
  );

  // A full turn is the 32-bit wrap, so pi*n/128 is n placed at bit 24;
  // only the top byte is kept since the offset cannot touch lower bits.
  always_ff @(posedge clock) begin
    if (rst) begin
      carrierPhase_reg <= tuner_pkg::BYTE_RESET;
    end else begin
      carrierPhase_reg <= carrierIf.phase[tuner_pkg::OFFSET_SHIFT +:
        tuner_pkg::OFFSET_W] + phaseOffset_reg; // RL7
    end
  end

  // Accumulators outside this block see the same clear level.
  always_ff @(posedge clock) begin
    if (rst) begin
      clear_reg <= 1'b0;
    end else begin
      clear_reg <= chipConfig_reg[tuner_pkg::CFG_CLEAR]; // RL6
    end
  end

  // ---------------------------------------------------------------------
  // Sample phase
  // ---------------------------------------------------------------------
  assign phaseUpdate = chipConfig_reg[tuner_pkg::CFG_SPH_CONT] ||
    dataReadyIn; // RL4

  always_ff @(posedge clock) begin
    if (rst) begin
      samplePhase_reg <= '0;
      sampleStrobe_reg <= 1'b0;
    end else if (phaseUpdate) begin
      samplePhase_reg <= tuner_pkg::sph_select(resampIf.phase, // RL3
        chipConfig_reg[tuner_pkg::CFG_SPH_SEL_LO +: tuner_pkg::SEL_W]);
      sampleStrobe_reg <= resampIf.carry;
    end
  end

  // ---------------------------------------------------------------------
  // Output forcing
  // ---------------------------------------------------------------------
  output_forcer forcer (
    .clock(clock),
    .rst(rst),
    .testMode(testMode_reg),
    .forceWord(outputForce_reg),
    .samplePhaseIn(samplePhase_reg),
    .sampleStrobeIn(sampleStrobe_reg),
    .levelCompareIn(levelCompareIn),
    .inphaseIn(inphaseIn),
    .dataReadyIn(dataReadyIn),
    .terminalIn(carrierIf.carry),
    .quadratureIn(quadratureIn),
    .samplePhaseOut(samplePhaseOut),
    .sampleStrobeOut(sampleStrobeOut),
    .levelCompareOut(levelCompareOut),
    .inphaseOut(inphaseOut),
    .dataReadyOut(outputDataReady),
    .terminalOut(carrierTerminalPhaseOut),
    .quadratureOut(quadratureOut)
  );

  assign controlBusOut = busOut_reg;
  assign controlBusOeN = busOeN_reg;
  assign carrierPhaseOut = carrierPhase_reg;
  assign clearAccumulators = clear_reg;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_carrier_hold;
    !carrierIf.load && !carrierIf.clear |=>
      carrierIf.phase == $past(carrierFreq);
  endproperty
  a_carrier_hold: assert property (p_carrier_hold) // RL1
    else $error("carrier phase advanced with load low");

  property p_resamp_hold;
    !resampIf.load && !resampIf.clear |=>
      resampIf.phase == $past(resampFreq);
  endproperty
  a_resamp_hold: assert property (p_resamp_hold) // RL2
    else $error("resampler phase advanced with load low");

  property p_phase_select;
    phaseUpdate |=> samplePhase_reg == tuner_pkg::sph_select(
      $past(resampIf.phase),
      $past(chipConfig_reg[tuner_pkg::CFG_SPH_SEL_LO +: tuner_pkg::SEL_W]));
  endproperty
  a_phase_select: assert property (p_phase_select) // RL3
    else $error("sample phase bits wrongly selected");

  property p_phase_frozen;
    !phaseUpdate |=> $stable(samplePhase_reg) && $stable(sampleStrobe_reg);
  endproperty
  a_phase_frozen: assert property (p_phase_frozen) // RL4
    else $error("sample phase changed without data ready");

  property p_clear_zero;
    chipConfig_reg[tuner_pkg::CFG_CLEAR] |=>
      carrierIf.phase == '0 && resampIf.phase == '0 && !resampIf.carry;
  endproperty
  a_clear_zero: assert property (p_clear_zero) // RL5
    else $error("accumulator not held at zero by clear");

  property p_clear_out;
    chipConfig_reg[tuner_pkg::CFG_CLEAR] [*2] |-> clearAccumulators;
  endproperty
  a_clear_out: assert property (p_clear_out) // RL6
    else $error("clear not passed to external accumulators");

  property p_offset;
    1'b1 |=> carrierPhase_reg == 8'($past(carrierIf.phase[
      tuner_pkg::OFFSET_SHIFT +: tuner_pkg::OFFSET_W]) +
      $past(phaseOffset_reg));
  endproperty
  a_offset: assert property (p_offset) // RL7
    else $error("carrier phase offset not applied");

  property p_force_phase;
    testMode_reg |=> samplePhaseOut == $past(outputForce_reg[
      tuner_pkg::TST_SPH_LO +: tuner_pkg::SPH_W]) &&
      sampleStrobeOut == $past(outputForce_reg[tuner_pkg::TST_STROBE]);
  endproperty
  a_force_phase: assert property (p_force_phase) // RL8
    else $error("sample phase pins not forced");

  property p_force_iq;
    testMode_reg |=> inphaseOut == $past(outputForce_reg[
      tuner_pkg::TST_I_LO +: tuner_pkg::IQ_W]) &&
      quadratureOut == $past(outputForce_reg[
      tuner_pkg::TST_Q_LO +: tuner_pkg::IQ_W]) &&
      outputDataReady == $past(outputForce_reg[tuner_pkg::TST_READY]);
  endproperty
  a_force_iq: assert property (p_force_iq) // RL10
    else $error("data outputs not forced");

  property p_force_flags;
    testMode_reg |=> levelCompareOut ==
      $past(outputForce_reg[tuner_pkg::TST_LEVEL]) &&
      carrierTerminalPhaseOut ==
      $past(outputForce_reg[tuner_pkg::TST_TERMINAL]);
  endproperty
  a_force_flags: assert property (p_force_flags) // RL11
    else $error("level or terminal output not forced");

  property p_no_force;
    !testMode_reg |=> inphaseOut == $past(inphaseIn) &&
      levelCompareOut == $past(levelCompareIn);
  endproperty
  a_no_force: assert property (p_no_force) // RL13
    else $error("outputs forced outside test mode");

  // A host read starts at the earliest two cycles after the transfer,
  // since its bus cycle begins on the clock after the transfer ends.
  property p_agc_capture;
    transfer && dest == tuner_pkg::DEST_AGC_SAMPLE ##2 rdStrobe |=>
      controlBusOut == $past(agcAccumIn, 3) && !controlBusOeN;
  endproperty
  a_agc_capture: assert property (p_agc_capture) // RL14
    else $error("captured AGC value not read back");

  property p_bus_idle;
    !rdStrobe |=> controlBusOeN && controlBusOut == tuner_pkg::BYTE_RESET;
  endproperty
  a_bus_idle: assert property (p_bus_idle) // RL14
    else $error("control bus driven without a read");

  property p_config_reserved;
    chipConfig_reg[tuner_pkg::CFG_CARRIER_LOAD-1:0] == '0 &&
      chipConfig_reg[tuner_pkg::WORD_W-1:tuner_pkg::CFG_CLEAR+1] == '0;
  endproperty
  a_config_reserved: assert property (p_config_reserved) // RL16
    else $error("reserved configuration bits were stored");

endmodule

// [tuner_host.sv]
`timescale 1ns/1ps
module tuner_host (
  input wire logic clock,
  input wire logic [7:0] controlBusOut,
  input wire logic controlBusOeN,
  output logic wrStrobe,
  output logic rdStrobe,
  output logic [2:0] busAddr,
  output logic [7:0] controlBusIn
);
  initial begin
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    busAddr = 3'h0;
    controlBusIn = 8'h00;
  end

  // -------------------------------------------------------------------
  // Bus cycles
  // -------------------------------------------------------------------
  // Four holding bytes, low byte first, then the transfer to dest.
  task automatic write_word(input logic [3:0] dest,
                            input logic [31:0] data);
    @(posedge clock);
    #1;
    wrStrobe = 1'b1;
    for (int i = 0; i < 5; i++) begin
      busAddr = (i < 4) ? 3'(i) : 3'h4;
      controlBusIn = (i < 4) ? data[8*i +: 8] : {4'h0, dest};
      @(posedge clock);
      #1;
    end
    wrStrobe = 1'b0;
    // A released bus must not keep showing the last byte.
    controlBusIn = ~controlBusIn;
  endtask

  // Read is held until the device turns its drivers on.
  task automatic read_byte(output logic [7:0] data);
    @(posedge clock);
    #1;
    rdStrobe = 1'b1;
    data = 8'hxx;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      #1;
      if (controlBusOeN === 1'b0) begin
        data = controlBusOut;
        break;
      end
    end
    rdStrobe = 1'b0;
  endtask
endmodule

// [tuner_pkg.sv]
package tuner_pkg;

  // ---------------------------------------------------------------------
  // Control bus addressing
  // ---------------------------------------------------------------------
  localparam logic [2:0] ADDR_HOLD0 = 3'h0;
  localparam logic [2:0] ADDR_HOLD1 = 3'h1;
  localparam logic [2:0] ADDR_HOLD2 = 3'h2;
  localparam logic [2:0] ADDR_HOLD3 = 3'h3;
  localparam logic [2:0] ADDR_TRANSFER = 3'h4;
  localparam int DEST_W = 4;
  localparam logic [3:0] DEST_DECIM_CTRL = 4'h4;
  localparam logic [3:0] DEST_CHIP_CONFIG = 4'h6;
  localparam logic [3:0] DEST_PHASE_OFFSET = 4'h7;
  localparam logic [3:0] DEST_OUTPUT_FORCE = 4'h8;
  localparam logic [3:0] DEST_AGC_SAMPLE = 4'h9;

  // ---------------------------------------------------------------------
  // Widths and field positions
  // ---------------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int WORD_W = 32;
  localparam int PHASE_W = 32;
  localparam int SPH_W = 5;
  localparam int IQ_W = 10;
  localparam int AGC_W = 8;
  localparam int OFFSET_W = 8;
  localparam int SEL_W = 2;
  localparam int OFFSET_SHIFT = 24;
  localparam int SPH_BASE = 24;
  localparam int DECIM_TEST_EN = 3;
  localparam int CFG_CARRIER_LOAD = 9;
  localparam int CFG_RESAMP_LOAD = 10;
  localparam int CFG_SPH_SEL_LO = 11;
  localparam int CFG_SPH_CONT = 13;
  localparam int CFG_CLEAR = 14;
  localparam int TST_SPH_LO = 0;
  localparam int TST_STROBE = 5;
  localparam int TST_LEVEL = 6;
  localparam int TST_I_LO = 7;
  localparam int TST_READY = 17;
  localparam int TST_TERMINAL = 18;
  localparam int TST_Q_LO = 19;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [31:0] CHIP_CONFIG_RESET = 32'h0000_0600;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  function automatic logic [SPH_W-1:0] sph_select(
    input logic [PHASE_W-1:0] acc,
    input logic [SEL_W-1:0] sel
  );
    sph_select = acc[SPH_BASE + int'(sel) +: SPH_W];
  endfunction

endpackage
